// ### logic/i2cm_cfg.svh
`ifndef I2CM_CFG_SVH
`define I2CM_CFG_SVH
// Behaviour
// [R1] Low five control bits are self-clearing start/restart/stop/receive/ack requests
// [R2] Request field is one-hot while an event runs, start at bit 0
// [R3] Transmit-active status bit 14 is high while shifting with request field zero
// [R4] Software sequences whole messages; the device performs one portion per request
// [R5] Master interrupt flag rises when any requested event completes
// [R6] Start request while master logic is inactive begins a start event
// [R7] Writing the transmit buffer starts a master byte transmission
// [R8] Receive request starts byte reception; reading receive buffer clears receive-full
// [R9] Acknowledge event drives the ack value: 1 gives not-acknowledge, 0 acknowledge
// [R10] Restart request starts repeated start; stop request starts stop event
// [R11] Clock synchronisation and arbitration are always active, no enable
// [R12] Software keeps management-address enable, control bit 11, cleared as master
// [R13] After clock release the baud counter stops until clock is sampled high
// [R14] Clock sampled high reloads the 9-bit reload value and counting resumes
// [R15] Baud counter decrements twice per cycle; clock output toggles on rollover
// [R16] Clock sampled low at rollover holds the counter, allowing stretching
// [R17] Clock sampled once per cycle; rollover follows on the next cycle
// [R18] While busy, request writes are ignored; transmit writes dropped, set collision
// [R19] Acknowledge lasts two baud periods, then clears its bit and interrupts
// [R20] Lost arbitration sets bus-collision bit 10, interrupts, releases the port
// [R21] Software sets one request bit only while the whole field reads zero

// ****************************************
// Widths and status layout
// ****************************************
`define I2CM_BAUD_W 9
`define I2CM_BYTE_W 8
`define I2CM_STAT_W 16
`define I2CM_STAT_TBF 0
`define I2CM_STAT_RBF 1
`define I2CM_STAT_WCOL 7
`define I2CM_STAT_BCL 10
`define I2CM_STAT_MGMT 11
`define I2CM_STAT_TXACT 14

// ****************************************
// Timing and step counts
// ****************************************
`define I2CM_CLK_PERIOD_NS 10
`define I2CM_BAUD_DEC 2
`define I2CM_START_LAST 4'h1
`define I2CM_SEQ_LAST 4'h2
`define I2CM_LAST_DATA_BIT 4'h7
`define I2CM_XMIT_ACK_BIT 4'h8
`endif

// ### logic/i2cm_pkg.sv
package i2cm_pkg;
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_START   = 7'h02,
    ST_RESTART = 7'h04,
    ST_STOP    = 7'h08,
    ST_XMIT    = 7'h10,
    ST_RECV    = 7'h20,
    ST_ACK     = 7'h40
  } i2cm_state_t;

  // Bit order matches the low five control bits
  typedef struct packed {
    logic ack_sequence_request;
    logic receive_request;
    logic stop_request;
    logic restart_request;
    logic start_request;
  } i2cm_req_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cm_lines_t;
endpackage

// ### logic/i2cm_baud.sv
`timescale 1ns/1ps
`include "i2cm_cfg.svh"
module i2cm_baud import i2cm_pkg::*; #(
  parameter int BAUD_W = `I2CM_BAUD_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic scl_released,
  input wire logic scl_high,
  input wire logic [BAUD_W-1:0] reload_value,
  output logic tick
);
  logic [BAUD_W-1:0] baud_counter;
  logic waiting;
  logic released_d;

  wire release_edge = scl_released && !released_d;
  wire suspend = (waiting || release_edge) && !scl_high;
  wire resume = waiting && scl_high;
  wire at_rollover = baud_counter < BAUD_W'(`I2CM_BAUD_DEC);
  wire stretched = at_rollover && scl_released && !scl_high;
  wire next_tick = run && !suspend && !resume && at_rollover && !stretched;
  logic [BAUD_W-1:0] next_counter;

  always_comb begin
    if (!run || resume || next_tick) begin
      next_counter = reload_value; // see [R14]
    end else if (suspend || stretched) begin
      next_counter = baud_counter; // see [R13] see [R16]
    end else begin
      next_counter = baud_counter - BAUD_W'(`I2CM_BAUD_DEC); // see [R15]
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      baud_counter <= '0;
      waiting <= 1'b0;
      // Idle level of the release flag, so reset gives no false release edge
      released_d <= 1'b1;
      tick <= 1'b0;
    end else begin
      baud_counter <= next_counter;
      waiting <= run && (release_edge && !scl_high || waiting && !scl_high);
      released_d <= scl_released;
      tick <= next_tick; // see [R17]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_BAUD_SUSPEND: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R13]
    run && waiting && !scl_high |=> baud_counter == $past(baud_counter) && !tick)
    else $error("baud counter moved while clock held low after release");
  AST_BAUD_RELOAD: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R14]
    run && waiting && scl_high |=> baud_counter == $past(reload_value) && !waiting)
    else $error("baud counter not reloaded when clock seen high");
  AST_BAUD_DEC: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R15]
    run && !suspend && !resume && !at_rollover |=>
      baud_counter == $past(baud_counter) - BAUD_W'(`I2CM_BAUD_DEC))
    else $error("baud counter did not step by two");
  AST_BAUD_STRETCH: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [R16]
    run && !waiting && stretched |=> !tick && baud_counter == $past(baud_counter))
    else $error("rollover taken while clock stretched");
endmodule

// ### logic/i2cm_top.sv
`timescale 1ns/1ps
`include "i2cm_cfg.svh"
module i2cm_top import i2cm_pkg::*; #(
  parameter int BAUD_W = `I2CM_BAUD_W,
  parameter int BYTE_W = `I2CM_BYTE_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic control_wr,
  input wire i2cm_req_t control_req,
  input wire logic ack_value,
  input wire logic mgmt_address_enable,
  input wire logic transmit_wr,
  input wire logic [BYTE_W-1:0] transmit_buffer,
  input wire logic receive_rd,
  input wire logic write_collision_clr,
  input wire logic bus_collision_clr,
  input wire logic master_irq_clr,
  input wire logic [BAUD_W-1:0] baud_reload_value,
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  output i2cm_req_t control_low_reg,
  output logic [`I2CM_STAT_W-1:0] status_reg,
  output logic [BYTE_W-1:0] receive_buffer,
  output logic master_irq_flag,
  output logic ack_status
);
  function automatic logic one_hot(input i2cm_req_t r);
    return $onehot(r);
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  i2cm_lines_t line_meta;
  i2cm_lines_t line_sync;
  logic mgmt_meta;
  logic mgmt_sync;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_meta <= '1;
      line_sync <= '1;
      mgmt_meta <= 1'b0;
      mgmt_sync <= 1'b0;
    end else begin
      line_meta <= '{scl: serial_clock_line_in, sda: serial_data_line_in};
      line_sync <= line_meta;
      mgmt_meta <= mgmt_address_enable;
      mgmt_sync <= mgmt_meta;
    end
  end

  // ****************************************
  // State and decode
  // ****************************************
  i2cm_state_t state;
  logic [3:0] bitn;
  logic hi;
  logic [BYTE_W-1:0] shift;
  logic scl_low;
  logic sda_low;
  logic ack_bit;
  logic tick;
  logic write_collision;
  logic bus_collision_flag;
  logic transmit_full;
  logic transmit_active;
  logic receive_full;

  wire busy = state != ST_IDLE;
  // Non one-hot writes are dropped so the field can never hold two events
  wire ctl_take = control_wr && !busy && one_hot(control_req); // see [R18] see [R21]
  wire tx_take = transmit_wr && !busy; // see [R7]
  wire tx_reject = transmit_wr && busy; // see [R18]
  wire in_start = state == ST_START;
  wire in_restart = state == ST_RESTART;
  wire in_stop = state == ST_STOP;
  wire in_xmit = state == ST_XMIT;
  wire in_recv = state == ST_RECV;
  wire in_ack = state == ST_ACK;

  wire step_last = in_start && bitn == `I2CM_START_LAST
    || (in_restart || in_stop) && bitn == `I2CM_SEQ_LAST
    || in_xmit && hi && bitn == `I2CM_XMIT_ACK_BIT
    || in_recv && hi && bitn == `I2CM_LAST_DATA_BIT
    || in_ack && hi; // see [R19]

  // Arbitration runs in every event except reception; single master simply never loses
  wire lost = tick && (in_start && bitn == 4'h0 && !(line_sync.scl && line_sync.sda)
    || in_restart && bitn == 4'h1 && !line_sync.sda
    || in_stop && bitn == `I2CM_SEQ_LAST && !line_sync.sda
    || in_xmit && hi && bitn < `I2CM_XMIT_ACK_BIT && !sda_low && !line_sync.sda
    || in_ack && hi && !sda_low && !line_sync.sda); // see [R11] see [R20]
  wire ev_done = tick && step_last && !lost;
  wire recv_done = ev_done && in_recv;
  wire [BYTE_W-1:0] shift_in = {shift[BYTE_W-2:0], line_sync.sda};

  i2cm_baud #(.BAUD_W(BAUD_W)) u_baud (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(busy),
    .scl_released(!scl_low),
    .scl_high(line_sync.scl),
    .reload_value(baud_reload_value),
    .tick(tick)
  );

  // ****************************************
  // Event sequencer
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      control_low_reg <= '0;
      bitn <= 4'h0;
      hi <= 1'b0;
      shift <= '0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      ack_bit <= 1'b0;
    end else if (lost) begin
      state <= ST_IDLE; // see [R20]
      control_low_reg <= '0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else if (ev_done) begin
      state <= ST_IDLE; // see [R1] see [R19]
      control_low_reg <= '0;
      // A stop leaves the clock released so the bus can go idle
      scl_low <= !in_stop;
      sda_low <= in_stop ? 1'b0 : in_restart || in_start;
      if (in_recv) begin
        shift <= shift_in;
      end
    end else begin
      unique case (state)
        ST_IDLE: begin
          bitn <= 4'h0;
          hi <= 1'b0;
          if (ctl_take) begin
            control_low_reg <= control_req; // see [R1] see [R2]
            ack_bit <= ack_value;
            if (control_req.start_request) begin
              state <= ST_START; // see [R6]
            end else if (control_req.restart_request) begin
              state <= ST_RESTART; // see [R10]
              scl_low <= 1'b1;
              sda_low <= 1'b0;
            end else if (control_req.stop_request) begin
              state <= ST_STOP; // see [R10]
              scl_low <= 1'b1;
              sda_low <= 1'b1;
            end else if (control_req.receive_request) begin
              state <= ST_RECV; // see [R8]
              sda_low <= 1'b0;
            end else begin
              state <= ST_ACK;
              sda_low <= !ack_value; // see [R9]
            end
          end else if (tx_take) begin
            state <= ST_XMIT; // see [R7]
            shift <= transmit_buffer;
            sda_low <= !transmit_buffer[BYTE_W-1];
          end
        end
        ST_START, ST_RESTART, ST_STOP: begin
          if (tick) begin
            bitn <= bitn + 4'h1;
            if (in_start || bitn == 4'h1) begin
              sda_low <= in_start || in_restart;
            end else begin
              scl_low <= 1'b0;
            end
          end
        end
        ST_XMIT, ST_RECV, ST_ACK: begin
          if (tick && !hi) begin
            scl_low <= 1'b0; // see [R15]
            hi <= 1'b1;
          end else if (tick) begin
            scl_low <= 1'b1;
            hi <= 1'b0;
            bitn <= bitn + 4'h1;
            if (in_recv) begin
              shift <= shift_in;
            end else begin
              shift <= {shift[BYTE_W-2:0], 1'b0};
              sda_low <= bitn < `I2CM_LAST_DATA_BIT && !shift[BYTE_W-2];
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Flags, set wins over clear
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      master_irq_flag <= 1'b0;
      bus_collision_flag <= 1'b0;
      write_collision <= 1'b0;
      transmit_full <= 1'b0;
      transmit_active <= 1'b0;
      receive_full <= 1'b0;
      receive_buffer <= '0;
      ack_status <= 1'b0;
    end else begin
      master_irq_flag <= ev_done || lost || master_irq_flag && !master_irq_clr; // see [R5]
      bus_collision_flag <= lost || bus_collision_flag && !bus_collision_clr; // see [R20]
      write_collision <= tx_reject || write_collision && !write_collision_clr; // see [R18]
      transmit_full <= tx_take || transmit_full && !lost
        && !(in_xmit && tick && hi && bitn == `I2CM_LAST_DATA_BIT);
      transmit_active <= tx_take || transmit_active && !lost && !ev_done; // see [R3]
      receive_full <= recv_done || receive_full && !receive_rd; // see [R8]
      if (recv_done) begin
        receive_buffer <= shift_in;
      end
      if (ev_done && in_xmit) begin
        ack_status <= line_sync.sda;
      end
    end
  end

  assign serial_clock_line_out = 1'b0;
  assign serial_data_line_out = 1'b0;
  assign serial_clock_line_oe = scl_low;
  assign serial_data_line_oe = sda_low;
  always_comb begin
    status_reg = '0;
    status_reg[`I2CM_STAT_TBF] = transmit_full;
    status_reg[`I2CM_STAT_RBF] = receive_full;
    status_reg[`I2CM_STAT_WCOL] = write_collision;
    status_reg[`I2CM_STAT_BCL] = bus_collision_flag;
    // Mirror only; software must keep it clear in master use
    status_reg[`I2CM_STAT_MGMT] = mgmt_sync; // see [R12]
    status_reg[`I2CM_STAT_TXACT] = transmit_active;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_ack_first_tick;
    in_ack && tick && !hi && !lost;
  endsequence
  sequence s_start_taken;
    ctl_take && control_req.start_request;
  endsequence
  sequence s_restart_taken;
    ctl_take && control_req.restart_request;
  endsequence
  sequence s_stop_taken;
    ctl_take && control_req.stop_request;
  endsequence

  AST_REQ_ONEHOT: assert property ($onehot0(control_low_reg)) // see [R2]
    else $error("request field not one-hot");
  AST_REQ_IDLE_ZERO: assert property ((state == ST_IDLE || in_xmit) |-> control_low_reg == '0) // see [R1]
    else $error("request bit left set without its event");
  AST_TXACT: assert property (transmit_active |-> control_low_reg == '0 && in_xmit) // see [R3]
    else $error("transmit active outside transmission");
  AST_START_BEGIN: assert property (s_start_taken |=> in_start && control_low_reg.start_request) // see [R6]
    else $error("start request did not begin start event");
  AST_TX_BEGIN: assert property (tx_take |=> in_xmit && transmit_active && transmit_full) // see [R7]
    else $error("transmit write did not start transmission");
  AST_RBF_CLR: assert property (receive_rd && !recv_done |=> !receive_full) // see [R8]
    else $error("receive read did not clear receive-full");
  AST_ACK_LEVEL: assert property (in_ack |-> sda_low == !ack_bit) // see [R9]
    else $error("acknowledge level differs from ack value");
  AST_IRQ: assert property (ev_done |=> master_irq_flag && state == ST_IDLE) // see [R5]
    else $error("completed event raised no interrupt");
  AST_WCOL: assert property (tx_reject |=> write_collision) // see [R18]
    else $error("busy transmit write did not flag collision");
  AST_CTL_IGNORE: assert property (control_wr && busy && !ev_done && !lost |=> // see [R18]
    $stable(control_low_reg))
    else $error("request write accepted while busy");
  AST_ACK_LEN: assert property (s_ack_first_tick |=> in_ack && hi) // see [R19]
    else $error("acknowledge ended before two baud periods");
  AST_BCL: assert property (lost |=> bus_collision_flag && master_irq_flag // see [R20]
    && state == ST_IDLE && !serial_clock_line_oe && !serial_data_line_oe)
    else $error("arbitration loss not handled");
  AST_RESTART_BEGIN: assert property (s_restart_taken |=> in_restart // see [R10]
    && serial_clock_line_oe && !serial_data_line_oe)
    else $error("restart request did not begin repeated start");
  AST_STOP_BEGIN: assert property (s_stop_taken |=> in_stop // see [R10]
    && serial_clock_line_oe && serial_data_line_oe)
    else $error("stop request did not begin stop event");
  AST_STOP_RELEASE: assert property (ev_done && in_stop |=> // see [R10]
    !serial_clock_line_oe && !serial_data_line_oe)
    else $error("stop left a line driven");
  AST_RECV_BEGIN: assert property (ctl_take && control_req.receive_request |=> // see [R8]
    in_recv && control_low_reg.receive_request && !serial_data_line_oe)
    else $error("receive request did not begin reception");
  AST_RECV_DONE: assert property (recv_done |=> receive_full // see [R8]
    && receive_buffer == $past(shift_in) && control_low_reg == '0)
    else $error("received byte not delivered");
  AST_TBF_CLR: assert property (in_xmit && tick && hi && bitn == `I2CM_LAST_DATA_BIT // see [R7]
    && !lost |=> !transmit_full)
    else $error("transmit-full not cleared after eighth bit");
endmodule

// ### sim/i2cm_slave.sv
`timescale 1ns/1ps
module i2cm_slave (
  input wire logic sys_clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic tx_mode,
  input wire logic collide,
  input wire logic [7:0] tx_byte,
  input wire logic [3:0] stretch,
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] rx_byte,
  output logic last_bit,
  output int starts,
  output int stops
);
  int bit_cnt = 0;
  logic [7:0] shift = 8'h00;
  logic [3:0] hold = 4'h0;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic in_byte;
  initial begin
    starts = 0;
    stops = 0;
    rx_byte = 8'h00;
    last_bit = 1'b1;
  end
  // ****************************************
  // Framing and bit capture
  // ****************************************
  always @(posedge scl) begin
    last_bit = sda;
    if (in_byte) begin
      shift = {shift[6:0], sda};
    end
    if (bit_cnt == 7) begin
      rx_byte = shift;
    end
  end
  always @(negedge scl) begin
    bit_cnt = (bit_cnt == 8) ? 0 : bit_cnt + 1;
  end
  // ****************************************
  // Stretching and line pulls
  // ****************************************
  // Stretch counted in system cycles so the master must wait on a real low
  // Start and stop judged on settled samples: the master moves both lines
  // on one edge, and an event-driven check would race that update
  always @(posedge sys_clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin
      starts++;
      bit_cnt = -1;
    end
    if (scl && scl_q && !sda_q && sda) begin
      stops++;
    end
    if (scl_q && !scl) begin
      hold <= stretch;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end
  assign in_byte = bit_cnt >= 0 && bit_cnt < 8;
  assign scl_pull = hold != 4'h0;
  // Collide pulls data low over a whole byte, so a released one is lost
  assign sda_pull = in_byte ? (collide || (tx_mode && !tx_byte[7 - bit_cnt]))
    : (bit_cnt == 8 && !tx_mode);
endmodule

// ### sim/i2cm_top_test.sv
`timescale 1ns/1ps
module i2cm_top_test import i2cm_pkg::*;;
  localparam int RELOAD = 4;
  localparam int HMIN = RELOAD / 2 + 1;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic control_wr = 1'b0;
  i2cm_req_t control_req = '0;
  logic ack_value = 1'b0;
  logic transmit_wr = 1'b0;
  logic [7:0] transmit_buffer = 8'h00;
  logic receive_rd = 1'b0;
  logic wcol_clr = 1'b0;
  logic irq_clr = 1'b0;
  logic tx_mode = 1'b0;
  logic collide = 1'b0;
  logic [7:0] slave_tx = 8'h00;
  logic [3:0] stretch = 4'h0;
  logic scl_oe, sda_oe, irq, ack_status, scl_pull, sda_pull, last_bit;
  logic scl_out, sda_out;
  logic [15:0] status;
  i2cm_req_t field;
  logic [7:0] rx_buf, slave_rx;
  int starts, stops;
  int fails = 0;
  int total_checks = 0;
  int hi = 0;
  logic [31:0] seed = 32'h695831e1;
  logic [7:0] exp_q[$];
  wire scl = !(scl_oe || scl_pull);
  wire sda = !(sda_oe || sda_pull);

  i2cm_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .control_wr(control_wr),
    .control_req(control_req), .ack_value(ack_value),
    .mgmt_address_enable(1'b0),
    .transmit_wr(transmit_wr), .transmit_buffer(transmit_buffer), .receive_rd(receive_rd),
    .write_collision_clr(wcol_clr), .bus_collision_clr(1'b0), .master_irq_clr(irq_clr),
    .baud_reload_value(9'(RELOAD)), .serial_clock_line_in(scl), .serial_clock_line_out(scl_out),
    .serial_clock_line_oe(scl_oe), .serial_data_line_in(sda), .serial_data_line_out(sda_out),
    .serial_data_line_oe(sda_oe), .control_low_reg(field), .status_reg(status),
    .receive_buffer(rx_buf), .master_irq_flag(irq), .ack_status(ack_status));

  i2cm_slave peer (.sys_clk(sys_clk), .scl(scl), .sda(sda), .tx_mode(tx_mode),
    .collide(collide), .tx_byte(slave_tx), .stretch(stretch), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .rx_byte(slave_rx), .last_bit(last_bit), .starts(starts),
    .stops(stops));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic req(input int idx, input logic av);
    step();
    control_wr = 1'b1;
    control_req = i2cm_req_t'(5'h01 << idx);
    ack_value = av;
    step();
    control_wr = 1'b0;
    step();
    chk("field", 16'h1 << idx, 16'(field));
  endtask

  task automatic finish_evt();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      step();
      n++;
    end
    chk("irq", 16'h1, {15'h0, irq});
    chk("field idle", 16'h0, 16'(field));
    irq_clr = 1'b1;
    step();
    irq_clr = 1'b0;
  endtask

  task automatic send(input logic [7:0] b, input logic poke);
    step();
    transmit_wr = 1'b1;
    transmit_buffer = b;
    exp_q.push_back(b);
    step();
    if (poke) begin
      transmit_buffer = ~b;
      control_wr = 1'b1;
      control_req = i2cm_req_t'(5'h01);
      step();
    end
    transmit_wr = 1'b0;
    control_wr = 1'b0;
    step();
    chk("tx active", poke ? 16'h4081 : 16'h4001, status & 16'h4081);
    chk("field busy", 16'h0, 16'(field));
    wcol_clr = 1'b1;
    step();
    wcol_clr = 1'b0;
    finish_evt();
    chk("slave byte", 16'(exp_q.pop_front()), 16'(slave_rx));
    chk("ack seen", 16'h0, 16'(ack_status));
    chk("tx idle", 16'h0, status & 16'h4081);
  endtask

  task automatic recv(input logic av);
    seed = lfsr(seed);
    slave_tx = seed[7:0];
    tx_mode = 1'b1;
    req(3, 1'b0);
    finish_evt();
    chk("rx byte", 16'(slave_tx), 16'(rx_buf));
    chk("rx full", 16'h2, status & 16'h2);
    receive_rd = 1'b1;
    step();
    receive_rd = 1'b0;
    step();
    chk("rx clear", 16'h0, status & 16'h2);
    req(4, av);
    finish_evt();
    tx_mode = 1'b0;
    chk("ack level", 16'(av), 16'(last_bit));
  endtask

  task automatic note(input string name);
    $display("test %s done", name);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************
  // Clock high-time monitor
  // ****************************************
  // Only while starts outnumber stops; the repeated start keeps that true over idle bus after the stop
  always @(posedge sys_clk) begin
    if (scl) begin
      hi++;
    end else begin
      if (hi != 0 && starts > stops) begin
        chk("scl high time", 16'h1, 16'(hi >= HMIN));
      end
      hi = 0;
    end
  end

  initial begin
    #200000;
    fails++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    end_sim();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    chk("reset status", 16'h0, status);
    chk("reset lines", 16'h0, {12'h0, scl_out, sda_out, scl_oe, sda_oe});
    req(0, 1'b0);
    finish_evt();
    chk("start lines", 16'h3, {14'h0, scl_oe, sda_oe});
    chk("starts", 16'h1, 16'(starts));
    note("start");
    seed = lfsr(seed);
    send({seed[7:1], 1'b0}, 1'b1);
    seed = lfsr(seed);
    stretch = {1'b0, seed[2:0]} + 4'h2;
    send(seed[7:0], 1'b0);
    stretch = 4'h0;
    note("transmit");
    req(1, 1'b0);
    finish_evt();
    chk("restarts", 16'h2, 16'(starts));
    seed = lfsr(seed);
    send({seed[7:1], 1'b1}, 1'b0);
    recv(1'b0);
    recv(1'b1);
    note("receive ack");
    req(2, 1'b0);
    finish_evt();
    chk("stops", 16'h1, 16'(stops));
    chk("stop lines", 16'h0, {14'h0, scl_oe, sda_oe});
    note("stop");
    control_wr = 1'b1;
    control_req = i2cm_req_t'(5'h03);
    step();
    control_wr = 1'b0;
    step();
    chk("two requests", 16'h0, 16'(field));
    req(0, 1'b0);
    finish_evt();
    collide = 1'b1;
    step();
    transmit_wr = 1'b1;
    transmit_buffer = 8'hff;
    step();
    transmit_wr = 1'b0;
    finish_evt();
    chk("bus collision", 16'h0400, status & 16'h4481);
    chk("lost lines", 16'h0, {14'h0, scl_oe, sda_oe});
    collide = 1'b0;
    note("collision");
    end_sim();
  end
endmodule
